/* design/nbb_host.sv */
/*
 Host-side NAND sequencer: waits out the device power-on reset, scans factory
 bad-block markers into a table, then runs program and erase requests with a
 status check, retiring failed blocks and moving program data to a good block.
 Assumes an outside command engine that turns each operation into pin cycles and
 keeps the page data in its own buffer so a program can be repeated elsewhere.
*/
`timescale 1ns/1ps

module nbb_host
    import nbb_pkg::*;
#(
    parameter int POR_WAIT_CYC = nbb_pkg::POR_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device pins
    input wire logic ready_busy_n,
    output logic write_protect_n,
    // Command engine
    output logic eng_req,
    output nbb_pkg::nbb_op_t eng_op,
    output logic [nbb_pkg::BLK_W-1:0] eng_block,
    output logic eng_page,
    input wire logic eng_ack,
    input wire logic [7:0] eng_data,
    // User requests
    input wire logic small_density,
    input wire logic usr_req,
    input wire logic usr_erase,
    input wire logic [nbb_pkg::BLK_W-1:0] usr_block,
    output logic usr_ready,
    output logic usr_done,
    output logic usr_fail,
    output logic [nbb_pkg::BLK_W-1:0] usr_phys_block,
    // Status
    output logic scan_done,
    output logic [nbb_pkg::BLK_W:0] bad_count
);
    import nbb_pkg::*;

    typedef struct packed {
        nbb_state_t st;
        logic [2:0] sync;
        logic rb;
        logic seen_busy;
        logic [18:0] cnt;
        logic [10:0] last;
        logic [10:0] cur;
        logic [11:0] tries;
        logic erase;
        logic page;
        logic req;
        nbb_op_t op;
        logic wp_n;
        logic done;
        logic fail;
        logic scanned;
        logic [11:0] bad_cnt;
        logic we;
        logic wdata;
        logic [10:0] waddr;
        logic [10:0] raddr;
    } nbb_host_state_t;

    nbb_host_state_t s_r;
    nbb_host_state_t s_nxt;
    logic tbl_bad;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Anything but erased FFh counts as a marker; the factory writes 00h
    function automatic logic marker_bad(input logic [7:0] d);
        marker_bad = (d != MARK_GOOD);
    endfunction

    function automatic logic [10:0] next_blk(input logic [10:0] b, input logic [10:0] last);
        next_blk = (b == last) ? 11'h000 : 11'(b + 11'h001);
    endfunction

    // --------------------------------------------------------------
    // Table memory
    // --------------------------------------------------------------
    nbb_tbl i_nbb_tbl (
        .clk(clk),
        .we(s_r.we),
        .waddr(s_r.waddr),
        .wdata(s_r.wdata),
        .raddr(s_r.raddr),
        .rdata(tbl_bad)
    );

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    // Next-state logic for the whole block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.done = 1'b0;
        // Pin passes three flops; a level counts once the last two agree
        s_nxt.sync = {s_r.sync[1:0], ready_busy_n};
        if (s_r.sync[1] == s_r.sync[2])
        begin
            s_nxt.rb = s_r.sync[2];
        end
        // Request is a level that falls the cycle after its acknowledge
        if (eng_ack)
        begin
            s_nxt.req = 1'b0;
        end
        case (s_r.st)
            S_POR:
            begin
                s_nxt.wp_n = 1'b0;
                s_nxt.cnt = 19'(s_r.cnt + 19'h00001);
                if (!s_r.rb)
                begin
                    s_nxt.seen_busy = 1'b1;
                end
                // Either the line came back high or the fixed wait ran out
                if ((s_r.seen_busy && s_r.rb) || (s_r.cnt >= 19'(POR_WAIT_CYC - 1)))
                begin
                    s_nxt.st = S_SCAN;
                    s_nxt.cur = 11'h000;
                    s_nxt.page = 1'b0;
                    s_nxt.last = small_density ? BLK_LAST_1G : BLK_LAST_BIG;
                end
            end
            S_SCAN:
            begin
                if (s_r.cur <= BLK_BOOT_LAST)
                begin
                    s_nxt.we = 1'b1;
                    s_nxt.waddr = s_r.cur;
                    s_nxt.wdata = 1'b0;
                    s_nxt.cur = 11'(s_r.cur + 11'h001);
                end
                else if (!s_r.req && !eng_ack)
                begin
                    s_nxt.req = 1'b1;
                    s_nxt.op = OP_READ_MARK;
                end
                else if (eng_ack)
                begin
                    // Bad on either page ends the block; a clean page 0 goes on to page 1
                    if (marker_bad(eng_data) || s_r.page)
                    begin
                        s_nxt.we = 1'b1;
                        s_nxt.waddr = s_r.cur;
                        s_nxt.wdata = marker_bad(eng_data);
                        s_nxt.page = 1'b0;
                        if (marker_bad(eng_data))
                        begin
                            s_nxt.bad_cnt = 12'(s_r.bad_cnt + 12'h001);
                        end
                        if (s_r.cur == s_r.last)
                        begin
                            s_nxt.st = S_IDLE;
                            s_nxt.scanned = 1'b1;
                            s_nxt.wp_n = 1'b1;
                        end
                        else
                        begin
                            s_nxt.cur = 11'(s_r.cur + 11'h001);
                        end
                    end
                    else
                    begin
                        s_nxt.page = 1'b1;
                    end
                end
            end
            S_IDLE:
            begin
                // Erase only reaches here after the marker scan has finished
                if (usr_req)
                begin
                    s_nxt.erase = usr_erase;
                    s_nxt.cur = usr_block;
                    s_nxt.raddr = usr_block;
                    s_nxt.tries = 12'h000;
                    s_nxt.fail = 1'b0;
                    s_nxt.st = S_LOOK;
                end
            end
            S_LOOK:
            begin
                s_nxt.st = S_LOOKW;
            end
            S_LOOKW:
            begin
                if (tbl_bad)
                begin
                    // Bad block: erase refused, program moves on
                    if (s_r.erase)
                    begin
                        s_nxt.fail = 1'b1;
                        s_nxt.st = S_DONE;
                    end
                    else
                    begin
                        s_nxt.st = S_SEEK;
                    end
                end
                else
                begin
                    s_nxt.st = S_ISSUE;
                end
            end
            S_ISSUE:
            begin
                if (!s_r.req && !eng_ack)
                begin
                    s_nxt.req = 1'b1;
                    s_nxt.op = s_r.erase ? OP_ERASE : OP_PROGRAM;
                end
                else if (eng_ack)
                begin
                    s_nxt.cnt = 19'h00000;
                    s_nxt.st = S_EDGE;
                end
            end
            S_EDGE:
            begin
                // Line falls only after a short delay; plus synchroniser lag
                s_nxt.cnt = 19'(s_r.cnt + 19'h00001);
                if (s_r.cnt >= 19'(BUSY_EDGE_CNT + 19'h00003))
                begin
                    s_nxt.st = S_BUSY;
                end
            end
            S_BUSY:
            begin
                if (s_r.rb)
                begin
                    s_nxt.st = S_STAT;
                end
            end
            S_STAT:
            begin
                if (!s_r.req && !eng_ack)
                begin
                    s_nxt.req = 1'b1;
                    s_nxt.op = OP_STATUS;
                end
                else if (eng_ack)
                begin
                    if (eng_data[STAT_FAIL_BIT])
                    begin
                        s_nxt.we = 1'b1;
                        s_nxt.waddr = s_r.cur;
                        s_nxt.wdata = 1'b1;
                        s_nxt.bad_cnt = 12'(s_r.bad_cnt + 12'h001);
                        if (s_r.erase)
                        begin
                            s_nxt.fail = 1'b1;
                            s_nxt.st = S_DONE;
                        end
                        else
                        begin
                            s_nxt.st = S_SEEK;
                        end
                    end
                    else
                    begin
                        s_nxt.st = S_DONE;
                    end
                end
            end
            S_SEEK:
            begin
                // Walk upward, wrapping, until a good block; give up after a full lap
                if (s_r.tries > 12'(s_r.last))
                begin
                    s_nxt.fail = 1'b1;
                    s_nxt.st = S_DONE;
                end
                else
                begin
                    s_nxt.tries = 12'(s_r.tries + 12'h001);
                    s_nxt.cur = next_blk(s_r.cur, s_r.last);
                    s_nxt.raddr = next_blk(s_r.cur, s_r.last);
                    s_nxt.st = S_LOOK;
                end
            end
            S_DONE:
            begin
                s_nxt.done = 1'b1;
                s_nxt.st = S_IDLE;
            end
            default:
            begin
                s_nxt.st = S_POR;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.st <= S_POR;
            // Idle level of the pulled-up pin, so leaving reset is no false busy edge
            s_r.sync <= 3'h7;
            s_r.rb <= 1'b1;
            s_r.op <= OP_READ_MARK;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign write_protect_n = s_r.wp_n;
    assign eng_req = s_r.req;
    assign eng_op = s_r.op;
    assign eng_block = s_r.cur;
    assign eng_page = s_r.page;
    assign usr_ready = (s_r.st == S_IDLE);
    assign usr_done = s_r.done;
    assign usr_fail = s_r.fail;
    assign usr_phys_block = s_r.cur;
    assign scan_done = s_r.scanned;
    assign bad_count = s_r.bad_cnt;

endmodule

/* design/nbb_pkg.sv */
/*
 Constants shared by the bad-block managing NAND host sequencer and its table memory.
 Assumes a 100 MHz clock and a lower-level NAND command engine outside this block.
*/
package nbb_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int POR_WAIT_MS = 5;
    localparam int POR_CYC = POR_WAIT_MS * 1000 * CLK_MHZ;
    localparam int BUSY_EDGE_NS = 100;
    localparam int BUSY_EDGE_CYC = (BUSY_EDGE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [18:0] BUSY_EDGE_CNT = 19'(BUSY_EDGE_CYC);

    // ------------------------------------------------------------
    // Block geometry and markers
    // ------------------------------------------------------------
    localparam int BLK_W = 11;
    localparam int BLK_N = 2048;
    localparam logic [10:0] BLK_LAST_BIG = 11'h7ff;
    localparam logic [10:0] BLK_LAST_1G = 11'h3ff;
    localparam logic [10:0] BLK_BOOT_LAST = 11'h007;
    localparam logic [7:0] MARK_GOOD = 8'hff;
    localparam logic [7:0] MARK_BAD = 8'h00;
    localparam int STAT_FAIL_BIT = 0;

    // ------------------------------------------------------------
    // Operations handed to the command engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ_MARK = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_ERASE = 2'h2,
        OP_STATUS = 2'h3
    } nbb_op_t;

    typedef enum logic [3:0] {
        S_POR = 4'h0,
        S_SCAN = 4'h1,
        S_IDLE = 4'h2,
        S_LOOK = 4'h3,
        S_LOOKW = 4'h4,
        S_ISSUE = 4'h5,
        S_EDGE = 4'h6,
        S_BUSY = 4'h7,
        S_STAT = 4'h8,
        S_SEEK = 4'h9,
        S_DONE = 4'ha
    } nbb_state_t;

endpackage

/* design/nbb_tbl.sv */
/*
 Bad-block table: one bit per block, set means the block must not be used.
 Assumes one writer and one reader on the same clock; read data is registered.
*/
`timescale 1ns/1ps

module nbb_tbl
    import nbb_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [nbb_pkg::BLK_W-1:0] waddr,
    input wire logic wdata,
    // Read port
    input wire logic [nbb_pkg::BLK_W-1:0] raddr,
    output logic rdata
);
    logic mem [0:BLK_N-1];

    // No reset on the array: the scan writes every entry from block 0 to the density's last block before use
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

/* testbench/nbb_dev_model.sv */
/*
 Behavioural NAND device plus command engine for the host sequencer bench.
 Assumes the engine handshake of the host; busy times are short for simulation.
*/
`timescale 1ns/1ps

module nbb_dev_model
    import nbb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device pins
    output logic ready_busy_n,
    input wire logic write_protect_n,
    // Engine handshake
    input wire logic eng_req,
    input wire nbb_pkg::nbb_op_t eng_op,
    input wire logic [nbb_pkg::BLK_W-1:0] eng_block,
    input wire logic eng_page,
    output logic eng_ack,
    output logic [7:0] eng_data,
    // Count of marker reads that touched blocks 0-7
    output logic [7:0] boot_reads,
    // Keeps ready/busy high through power-on, as some boards never see it low
    input wire logic por_quiet
);
    import nbb_pkg::*;
    int cnt;
    logic [1:0] ph;
    logic fail;

    // Factory markers: a few bad blocks, one of them only in the large part
    function automatic logic [7:0] mark(input logic [10:0] b, input logic p);
        if (b == 11'h008 && !p || b == 11'h009 && p) return MARK_BAD;
        if (b == 11'h3ff || b == 11'h5dc) return MARK_BAD;
        return MARK_GOOD;
    endfunction

    // Busy countdown, then one request served at a time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ready_busy_n <= por_quiet;
            cnt <= por_quiet ? 0 : 20;
            ph <= 2'h0;
            eng_ack <= 1'b0;
            eng_data <= 8'h00;
            boot_reads <= 8'h00;
            fail <= 1'b0;
        end
        else
        begin
            eng_ack <= 1'b0;
            // Released data must not look valid to the host
            if (eng_ack)
                eng_data <= ~eng_data;
            // Requests are ignored while the power-on or op busy time runs
            if (cnt > 0)
            begin
                cnt <= cnt - 1;
                if (cnt == 1)
                    ready_busy_n <= 1'b1;
            end
            else if (ph == 2'h1)
            begin
                eng_ack <= 1'b1;
                ph <= 2'h0;
            end
            else if (ph == 2'h2)
            begin
                ready_busy_n <= 1'b0;
                cnt <= 30;
                ph <= 2'h0;
            end
            else if (eng_req && !eng_ack)
            begin
                if (eng_op == OP_READ_MARK)
                begin
                    ready_busy_n <= 1'b0;
                    cnt <= 3;
                    ph <= 2'h1;
                    eng_data <= mark(eng_block, eng_page);
                    if (eng_block <= BLK_BOOT_LAST)
                        boot_reads <= boot_reads + 8'h01;
                end
                else if (eng_op == OP_STATUS)
                begin
                    eng_ack <= 1'b1;
                    eng_data <= {7'h00, fail};
                end
                else
                begin
                    eng_ack <= 1'b1;
                    ph <= 2'h2;
                    // Worn blocks fail; a low write protect aborts the op
                    fail <= eng_block inside {11'h014, 11'h015, 11'h01e} || !write_protect_n;
                end
            end
        end
    end
endmodule

/* testbench/nbb_host_assertions.sv */
/*
 Checker for the NAND host sequencer, watching only its top-level ports.
 Assumes one clock domain and the synchronous active-high reset of the design.
*/
`timescale 1ns/1ps

module nbb_host_chk
    import nbb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device pins
    input wire logic ready_busy_n,
    input wire logic write_protect_n,
    // Command engine
    input wire logic eng_req,
    input wire nbb_pkg::nbb_op_t eng_op,
    input wire logic [nbb_pkg::BLK_W-1:0] eng_block,
    input wire logic eng_page,
    input wire logic eng_ack,
    // User side and status
    input wire logic small_density,
    input wire logic usr_done,
    input wire logic scan_done,
    input wire logic [nbb_pkg::BLK_W:0] bad_count
);
    import nbb_pkg::*;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    reset_quiet_a: assert property ($fell(rst) |-> !write_protect_n && !eng_req && !scan_done
        && !usr_done && bad_count == 12'h000) else $error("outputs not quiet after reset");
    first_ready_a: assert property ($rose(eng_req) |-> ready_busy_n)
        else $error("command raised while device busy");
    req_hold_a: assert property (eng_req && !eng_ack |=> eng_req && $stable(eng_op)
        && $stable(eng_block) && $stable(eng_page)) else $error("engine request moved before ack");
    req_drop_a: assert property (eng_req && eng_ack |=> !eng_req)
        else $error("engine request not dropped after ack");
    wp_scan_a: assert property (eng_req && eng_op == OP_READ_MARK |-> !write_protect_n)
        else $error("write protect open during scan");
    wp_open_a: assert property (eng_req && (eng_op == OP_PROGRAM || eng_op == OP_ERASE)
        |-> write_protect_n) else $error("program or erase with write protect low");
    erase_after_scan_a: assert property (eng_req && eng_op == OP_ERASE |-> scan_done)
        else $error("erase before markers scanned");
    boot_skip_a: assert property (eng_req && eng_op == OP_READ_MARK
        |-> eng_block > BLK_BOOT_LAST) else $error("marker read in boot blocks");
    scan_limit_a: assert property (eng_req && eng_op == OP_READ_MARK && small_density
        |-> eng_block <= BLK_LAST_1G) else $error("scan past last small block");
    status_after_a: assert property (eng_req && eng_ack
        && (eng_op == OP_PROGRAM || eng_op == OP_ERASE)
        |-> ##[14:80] (eng_req && eng_op == OP_STATUS)) else $error("no status read after op");
    done_pulse_a: assert property (usr_done |=> !usr_done) else $error("done longer than a cycle");
endmodule

bind nbb_host nbb_host_chk i_nbb_host_chk (.clk(clk), .rst(rst), .ready_busy_n(ready_busy_n),
    .write_protect_n(write_protect_n), .eng_req(eng_req), .eng_op(eng_op),
    .eng_block(eng_block), .eng_page(eng_page), .eng_ack(eng_ack),
    .small_density(small_density), .usr_done(usr_done), .scan_done(scan_done),
    .bad_count(bad_count));

/* testbench/nbb_host_test.sv */
/*
 Self-checking bench for the NAND host sequencer: scan, user ops, failures.
 Assumes the device model beside it and a shortened power-on wait.
*/
`timescale 1ns/1ps

module nbb_host_test;
    import nbb_pkg::*;
    logic clk, rst, ready_busy_n, write_protect_n, eng_req, eng_page, eng_ack;
    nbb_op_t eng_op;
    logic [10:0] eng_block, usr_block, usr_phys_block;
    logic [7:0] eng_data, boot_reads;
    logic small_density, usr_req, usr_erase, usr_ready, usr_done, usr_fail, scan_done;
    logic [11:0] bad_count;
    logic f, por_quiet;
    logic [10:0] pb;
    int reqs, fails, tests_run;
    // Shortened power-on wait, standing in for the fixed 5 ms
    localparam int POR_SIM = 50;

    nbb_host #(.POR_WAIT_CYC(POR_SIM)) i_nbb_host (.clk(clk), .rst(rst),
        .ready_busy_n(ready_busy_n),
        .write_protect_n(write_protect_n), .eng_req(eng_req), .eng_op(eng_op),
        .eng_block(eng_block), .eng_page(eng_page), .eng_ack(eng_ack), .eng_data(eng_data),
        .small_density(small_density), .usr_req(usr_req), .usr_erase(usr_erase),
        .usr_block(usr_block), .usr_ready(usr_ready), .usr_done(usr_done), .usr_fail(usr_fail),
        .usr_phys_block(usr_phys_block), .scan_done(scan_done), .bad_count(bad_count));
    nbb_dev_model i_nbb_dev_model (.clk(clk), .rst(rst), .ready_busy_n(ready_busy_n),
        .write_protect_n(write_protect_n), .eng_req(eng_req), .eng_op(eng_op),
        .eng_block(eng_block), .eng_page(eng_page), .eng_ack(eng_ack), .eng_data(eng_data),
        .boot_reads(boot_reads), .por_quiet(por_quiet));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Counts: %0d mismatches in %0d comparisons", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_num(input logic [11:0] got, input logic [11:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    // A stuck wait counts as a mismatch and ends the run
    task automatic tick(inout int n, input int lim);
        @(posedge clk);
        #1;
        n++;
        if (n > lim)
        begin
            fails++;
            $display("BAD at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask

    task automatic wait_scan();
        int n;
        n = 0;
        while (scan_done !== 1'b1)
            tick(n, 60000);
    endtask

    // One user request, taken while ready, then wait for its done pulse
    task automatic user_op(input logic er, input logic [10:0] b);
        int n;
        n = 0;
        reqs = 0;
        while (usr_ready !== 1'b1)
            tick(n, 100);
        usr_req = 1'b1;
        usr_erase = er;
        usr_block = b;
        tick(n, 100);
        usr_req = 1'b0;
        while (usr_done !== 1'b1)
        begin
            tick(n, 5000);
            if (eng_req === 1'b1)
                reqs++;
        end
        f = usr_fail;
        pb = usr_phys_block;
    endtask

    task automatic t_scan_small();
        wait_scan();
        chk_num(bad_count, 12'h003, "small scan bad count");
        chk_num({11'h000, write_protect_n}, 12'h001, "write protect after scan");
        chk_num({4'h0, boot_reads}, 12'h000, "boot block reads");
    endtask

    task automatic t_erase_bad();
        user_op(1'b1, 11'h008);
        chk_num({11'h000, f}, 12'h001, "erase of bad block not refused");
        chk_num(12'(reqs), 12'h000, "engine used for bad block");
    endtask

    task automatic t_prog_redirect();
        user_op(1'b0, 11'h009);
        chk_num({11'h000, f}, 12'h000, "redirected program fail");
        chk_num({1'b0, pb}, 12'h00a, "redirected block");
    endtask

    task automatic t_prog_fail();
        user_op(1'b0, 11'h014);
        chk_num({11'h000, f}, 12'h000, "program after replacement");
        chk_num({1'b0, pb}, 12'h016, "replacement block");
        chk_num(bad_count, 12'h005, "bad count after program fails");
    endtask

    task automatic t_erase_fail();
        user_op(1'b1, 11'h01e);
        chk_num({11'h000, f}, 12'h001, "erase failure reported");
        chk_num(bad_count, 12'h006, "bad count after erase fail");
    endtask

    task automatic t_boot_erase();
        user_op(1'b1, 11'h005);
        chk_num({11'h000, f}, 12'h000, "boot block erase");
        chk_num({1'b0, pb}, 12'h005, "boot block used");
    endtask

    task automatic t_wrap();
        user_op(1'b0, 11'h3ff);
        chk_num({1'b0, pb}, 12'h000, "wrap past last block");
    endtask

    // Second reset mid-run with the large density; the device stays ready, so only
    // the fixed wait may end power-on
    task automatic t_scan_big();
        int n;
        rst = 1'b1;
        small_density = 1'b0;
        por_quiet = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        n = 0;
        while (eng_req !== 1'b1)
            tick(n, 200);
        chk_num(12'(n >= POR_SIM), 12'h001, "command before power-on wait ended");
        wait_scan();
        chk_num(bad_count, 12'h004, "large scan bad count");
        user_op(1'b1, 11'h5dc);
        chk_num({11'h000, f}, 12'h001, "erase of high bad block");
    endtask

    initial
    begin
        rst = 1'b1;
        small_density = 1'b1;
        usr_req = 1'b0;
        usr_erase = 1'b0;
        usr_block = 11'h000;
        por_quiet = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_scan_small();
        t_erase_bad();
        t_prog_redirect();
        t_prog_fail();
        t_erase_fail();
        t_boot_erase();
        t_wrap();
        t_scan_big();
        report_and_stop();
    end
endmodule
